// File: common/bod_pkg.sv
// Purpose: Shared constants and types for the brownout detect control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Bit positions of control and flag fields are fixed here only.
package bod_pkg;

	// -------------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_RSTSRC  = 8'h04;
	localparam logic [7:0] OFS_IRQ_STA = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h10;

	// -------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------
	localparam int CTRL_MODE_LO  = 0;
	localparam int CTRL_MODE_HI  = 1;
	localparam int CTRL_IRQ_SEL  = 4;
	localparam int CTRL_DET_PD   = 5;
	localparam int CTRL_IRQ_EN   = 6;
	localparam int CTRL_GLB_EN   = 7;
	localparam int RST_PON_BIT   = 4;
	localparam int RST_BO_BIT    = 5;
	localparam int IRQ_N_EVENTS  = 2;
	localparam int EV_BO_IRQ     = 0;
	localparam int EV_BO_DETECT  = 1;

	// -------------------------------------------------------------------
	// Encodings and reset values
	// -------------------------------------------------------------------
	localparam logic [1:0]  MODE_TOTAL_PD = 2'h3;
	localparam logic [1:0]  MODE_RESET    = 2'h0;
	localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

	typedef struct packed {
		logic       global_irq_enable;
		logic       brownout_irq_enable;
		logic       detector_power_down;
		logic       brownout_irq_select;
		logic [1:0] power_reduction_mode;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{
		global_irq_enable:    1'b0,
		brownout_irq_enable:  1'b0,
		detector_power_down:  1'b0,
		brownout_irq_select:  1'b0,
		power_reduction_mode: MODE_RESET
	};

	typedef struct packed {
		logic brownout_flag;
		logic power_on_flag;
	} rst_flags_t;

endpackage

// File: core/brownout_detect_control.sv
// Purpose: Brownout detect control: enable logic, reset or interrupt routing,
//          sticky brownout and power-on flags, APB register access.
// Assumes: i_sys_rst is the power-on reset only; a brownout reset of the CPU
//          does not reset this block. Comparator input is synchronous.
// Notes:   Control and flags are reset by power-on reset only, which sets the power-on flag.
`timescale 1ns/100ps
module brownout_detect_control
	import bod_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_brownout_config_enable,
	input  wire logic        i_below_trip_voltage,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_cpu_reset,
	output logic             o_brownout_irq,
	output logic             o_irq,
	output logic             o_detect_active
);

	// -------------------------------------------------------------------
	// Register state
	// -------------------------------------------------------------------
	ctrl_t                   ctrl_reg;
	rst_flags_t              flags_reg;
	logic [IRQ_N_EVENTS-1:0] irq_sta_reg;
	logic [IRQ_N_EVENTS-1:0] irq_en_reg;
	logic                    por_pending_reg;
	logic                    brownout_prev_reg;
	logic                    pready_reg;
	logic                    pslverr_reg;
	logic [31:0]             prdata_reg;
	logic                    cpu_reset_reg;
	logic                    bo_irq_reg;
	logic                    irq_reg;
	logic                    active_reg;

	logic                    detect_active;
	logic                    brownout;
	logic                    irq_route;
	logic                    bo_rise;
	logic                    wr_en;
	logic                    setup;
	logic                    addr_ok;
	logic [IRQ_N_EVENTS-1:0] irq_set;
	logic [IRQ_N_EVENTS-1:0] irq_clr;
	logic [31:0]             rd_next;

	// -------------------------------------------------------------------
	// Detection enable and routing
	// -------------------------------------------------------------------
	// Fuse and comparator are taken as synchronous levels. A supply that
	// chatters around the trip point chatters the reset as well, since no
	// filtering is applied here.
	assign detect_active = i_brownout_config_enable
		&& (ctrl_reg.power_reduction_mode != MODE_TOTAL_PD)
		&& !ctrl_reg.detector_power_down;
	assign brownout  = detect_active && i_below_trip_voltage;
	assign irq_route = ctrl_reg.brownout_irq_select;
	assign bo_rise   = brownout && !brownout_prev_reg;

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			brownout_prev_reg <= 1'b0;
		else
			brownout_prev_reg <= brownout;
	end

	// Reset follows the live condition, so it stays asserted for the whole
	// brownout and drops one edge after the supply is back above trip.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cpu_reset_reg <= 1'b0;
		else
			cpu_reset_reg <= brownout && !irq_route;
	end

	// Interrupt request only when both enables are set; otherwise silent.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			bo_irq_reg <= 1'b0;
		else
			bo_irq_reg <= brownout && irq_route && ctrl_reg.brownout_irq_enable
				&& ctrl_reg.global_irq_enable;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			active_reg <= 1'b0;
		else
			active_reg <= detect_active;
	end

	// -------------------------------------------------------------------
	// APB decode
	// -------------------------------------------------------------------
	// Zero wait states keep the bus simple. An unmapped address answers with
	// an error and leaves every register untouched.
	assign setup = i_psel && !i_penable;
	assign wr_en = i_psel && i_penable && pready_reg && i_pwrite && !pslverr_reg;

	always_comb
	begin
		addr_ok = 1'b1;
		rd_next = RDATA_ZERO;
		if (i_paddr == OFS_CTRL)
		begin
			rd_next[CTRL_MODE_HI:CTRL_MODE_LO] = ctrl_reg.power_reduction_mode;
			rd_next[CTRL_IRQ_SEL] = ctrl_reg.brownout_irq_select;
			rd_next[CTRL_DET_PD]  = ctrl_reg.detector_power_down;
			rd_next[CTRL_IRQ_EN]  = ctrl_reg.brownout_irq_enable;
			rd_next[CTRL_GLB_EN]  = ctrl_reg.global_irq_enable;
		end
		else if (i_paddr == OFS_RSTSRC)
		begin
			rd_next[RST_BO_BIT]  = flags_reg.brownout_flag;
			rd_next[RST_PON_BIT] = flags_reg.power_on_flag;
		end
		else if (i_paddr == OFS_IRQ_STA)
			rd_next[IRQ_N_EVENTS-1:0] = irq_sta_reg;
		else if (i_paddr == OFS_IRQ_CLR)
			rd_next = RDATA_ZERO;
		else if (i_paddr == OFS_IRQ_EN)
			rd_next[IRQ_N_EVENTS-1:0] = irq_en_reg;
		else
			addr_ok = 1'b0;
	end

	// Every access completes in its first access cycle.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= RDATA_ZERO;
		end
		else
		begin
			pready_reg  <= setup;
			pslverr_reg <= setup && !addr_ok;
			if (setup && !i_pwrite)
				prdata_reg <= rd_next;
			else if (!setup)
				prdata_reg <= RDATA_ZERO;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			ctrl_reg <= CTRL_RESET;
		else if (wr_en && i_paddr == OFS_CTRL)
		begin
			ctrl_reg.power_reduction_mode <= i_pwdata[CTRL_MODE_HI:CTRL_MODE_LO];
			ctrl_reg.brownout_irq_select  <= i_pwdata[CTRL_IRQ_SEL];
			ctrl_reg.detector_power_down  <= i_pwdata[CTRL_DET_PD];
			ctrl_reg.brownout_irq_enable  <= i_pwdata[CTRL_IRQ_EN];
			ctrl_reg.global_irq_enable    <= i_pwdata[CTRL_GLB_EN];
		end
	end

	// -------------------------------------------------------------------
	// Reset source flags
	// -------------------------------------------------------------------
	// The configuration enable is a level, so it is sampled on the first edge
	// after power-on reset instead of inside the asynchronous reset branch.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			por_pending_reg <= 1'b1;
		else
			por_pending_reg <= 1'b0;
	end

	// Hardware set wins over a software zero write in the same cycle. Both
	// flags share one process so that the flag word has a single driver.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			flags_reg.power_on_flag <= 1'b1;
			flags_reg.brownout_flag <= 1'b0;
		end
		else
		begin
			if (wr_en && i_paddr == OFS_RSTSRC && !i_pwdata[RST_PON_BIT])
				flags_reg.power_on_flag <= 1'b0;
			if (brownout)
				flags_reg.brownout_flag <= 1'b1;
			else if (por_pending_reg && i_brownout_config_enable)
				flags_reg.brownout_flag <= 1'b1;
			else if (wr_en && i_paddr == OFS_RSTSRC && !i_pwdata[RST_BO_BIT])
				flags_reg.brownout_flag <= 1'b0;
		end
	end

	// -------------------------------------------------------------------
	// Interrupt status, clear and enable
	// -------------------------------------------------------------------
	always_comb
	begin
		irq_set = '0;
		irq_set[EV_BO_DETECT] = bo_rise;
		irq_set[EV_BO_IRQ]    = bo_rise && irq_route && ctrl_reg.brownout_irq_enable
			&& ctrl_reg.global_irq_enable;
		irq_clr = (wr_en && i_paddr == OFS_IRQ_CLR) ? i_pwdata[IRQ_N_EVENTS-1:0] : '0;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			irq_sta_reg <= '0;
		else
			irq_sta_reg <= (irq_sta_reg & ~irq_clr) | irq_set;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			irq_en_reg <= '0;
		else if (wr_en && i_paddr == OFS_IRQ_EN)
			irq_en_reg <= i_pwdata[IRQ_N_EVENTS-1:0];
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(((irq_sta_reg & ~irq_clr) | irq_set) & irq_en_reg);
	end

	assign o_prdata        = prdata_reg;
	assign o_pready        = pready_reg;
	assign o_pslverr       = pslverr_reg;
	assign o_cpu_reset     = cpu_reset_reg;
	assign o_brownout_irq  = bo_irq_reg;
	assign o_irq           = irq_reg;
	assign o_detect_active = active_reg;

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	a_reset_on_brownout: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		brownout && !ctrl_reg.brownout_irq_select |=> o_cpu_reset)
		else $error("brownout without irq routing gave no reset");

	a_irq_routing: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		brownout && irq_route && ctrl_reg.brownout_irq_enable
		&& ctrl_reg.global_irq_enable |=> o_brownout_irq && !o_cpu_reset)
		else $error("brownout irq routing failed");

	a_config_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_brownout_config_enable |=> !o_detect_active && !o_cpu_reset)
		else $error("detection active with config enable unprogrammed");

	a_total_pd_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		ctrl_reg.power_reduction_mode == MODE_TOTAL_PD |=> !o_detect_active)
		else $error("detection active in total power down");

	a_pd_bit_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		ctrl_reg.detector_power_down |=> !o_detect_active)
		else $error("detection active with detector powered down");

	a_flag_on_detect: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		detect_active && i_below_trip_voltage |=> flags_reg.brownout_flag)
		else $error("brownout flag not set on detection");

	a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		flags_reg.brownout_flag && !(wr_en && i_paddr == OFS_RSTSRC)
		|=> flags_reg.brownout_flag)
		else $error("brownout flag dropped without a write");

	a_por_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		por_pending_reg && i_brownout_config_enable
		|=> flags_reg.brownout_flag && flags_reg.power_on_flag)
		else $error("power-on did not set both flags");

	a_irq_gated: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		irq_route && !(ctrl_reg.brownout_irq_enable && ctrl_reg.global_irq_enable)
		|=> !o_cpu_reset && !o_brownout_irq)
		else $error("reset or irq with irq routing and enable cleared");

	a_power_flag_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$fell(flags_reg.power_on_flag) |->
		$past(wr_en) && $past(i_paddr) == OFS_RSTSRC && !$past(i_pwdata[RST_PON_BIT]))
		else $error("power-on flag cleared without a zero write");

	a_reset_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_cpu_reset && !brownout |=> !o_cpu_reset)
		else $error("reset held after brownout negated");

	a_supply_recovered: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_below_trip_voltage |=> !o_cpu_reset && !o_brownout_irq)
		else $error("reset or irq after supply recovered");

	a_route_exclusive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!(o_cpu_reset && o_brownout_irq))
		else $error("reset and irq raised together");

	a_flag_write_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$fell(flags_reg.brownout_flag) |->
		$past(wr_en) && $past(i_paddr) == OFS_RSTSRC && !$past(i_pwdata[RST_BO_BIT]))
		else $error("brownout flag cleared without a zero write");

	a_flag_quiet_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_brownout_config_enable && !flags_reg.brownout_flag |=> !flags_reg.brownout_flag)
		else $error("brownout flag set with config enable unprogrammed");

	a_power_flag_stays: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!flags_reg.power_on_flag |=> !flags_reg.power_on_flag)
		else $error("power-on flag set without a power-on");

	a_default_detect_on: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_brownout_config_enable && ctrl_reg == CTRL_RESET |=> o_detect_active)
		else $error("detection off with reset control values");

endmodule

// File: verif/brownout_detect_control_tb.sv
// Purpose: Self-checking bench for the brownout detect control block.
// Assumes: APB answers within 20 cycles; fuse and comparator are bench levels.
// Notes:   Table rows cover enable and routing; flags and interrupts follow.
`timescale 1ns/100ps
module brownout_detect_control_tb;
	import bod_pkg::*;
	typedef struct packed {
		logic       cfg;
		logic [7:0] ctrl;
		logic       below;
		logic       rst;
		logic       birq;
		logic       act;
	} row_t;
	logic        i_clk;
	logic        i_sys_rst;
	logic        cfg;
	logic        below;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cpu_reset;
	logic        brownout_irq;
	logic        irq;
	logic        detect_active;
	logic [7:0]  rst_cnt;
	logic [7:0]  irq_cnt;
	logic [31:0] rd;
	logic        err;
	int          err_count;
	int          cmp_count;
	row_t        rows [12] = '{
		'{1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0}, '{1'b0, 8'hD0, 1'b1, 1'b0, 1'b0, 1'b0},
		'{1'b1, 8'h03, 1'b1, 1'b0, 1'b0, 1'b0}, '{1'b1, 8'h20, 1'b1, 1'b0, 1'b0, 1'b0},
		'{1'b1, 8'h00, 1'b1, 1'b1, 1'b0, 1'b1}, '{1'b1, 8'h01, 1'b1, 1'b1, 1'b0, 1'b1},
		'{1'b1, 8'h02, 1'b1, 1'b1, 1'b0, 1'b1}, '{1'b1, 8'hD0, 1'b1, 1'b0, 1'b1, 1'b1},
		'{1'b1, 8'h50, 1'b1, 1'b0, 1'b0, 1'b1}, '{1'b1, 8'h90, 1'b1, 1'b0, 1'b0, 1'b1},
		'{1'b1, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1}, '{1'b1, 8'hD3, 1'b1, 1'b0, 1'b0, 1'b0}};

	brownout_detect_control dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_brownout_config_enable(cfg), .i_below_trip_voltage(below), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_cpu_reset(cpu_reset),
		.o_brownout_irq(brownout_irq), .o_irq(irq), .o_detect_active(detect_active));
	cpu_side_model cpu (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cpu_reset(cpu_reset),
		.i_brownout_irq(brownout_irq), .o_reset_count(rst_cnt), .o_irq_count(irq_cnt));

	always #50 i_clk = ~i_clk;

	// -------------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------------
	task automatic end_sim;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			$display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
			err_count++;
		end
	endtask

	// Request is held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			$display("BAD t=%0t no pready", $time);
			err_count++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse_low_supply(input int len);
		below <= 1'b1;
		repeat (len) @(posedge i_clk);
		below <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask

	initial
	begin
		repeat (20000) @(posedge i_clk);
		$display("BAD t=%0t run limit", $time);
		err_count++;
		end_sim();
	end

	// -------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------
	initial
	begin
		{i_clk, psel, penable, pwrite, below, err} = 6'h00;
		{i_sys_rst, cfg, paddr, pwdata, rd} = {1'b1, 1'b1, 8'h00, 32'h0000_0000, 32'h0000_0000};
		err_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		apb(1'b0, OFS_RSTSRC, 32'h0000_0000);
		chk(rd, 32'h0000_0030, "power-on flags");
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "ctrl reset");
		chk(32'(detect_active), 32'h0000_0001, "active after power-on");
		apb(1'b1, OFS_RSTSRC, 32'h0000_0020);
		apb(1'b0, OFS_RSTSRC, 32'h0000_0000);
		chk(rd, 32'h0000_0020, "clear power-on only");
		$display("reset test done");
		foreach (rows[i])
		begin
			below <= 1'b0;
			cfg   <= rows[i].cfg;
			apb(1'b1, OFS_CTRL, {24'h00_0000, rows[i].ctrl});
			apb(1'b1, OFS_RSTSRC, 32'h0000_0000);
			below <= rows[i].below;
			repeat (3) @(posedge i_clk);
			chk(32'(cpu_reset), 32'(rows[i].rst), "cpu reset");
			chk(32'(brownout_irq), 32'(rows[i].birq), "brownout irq");
			chk(32'(detect_active), 32'(rows[i].act), "detect active");
			apb(1'b0, OFS_RSTSRC, 32'h0000_0000);
			// Software disregards the flag while the fuse is unprogrammed.
			if (rows[i].cfg)
				chk(32'(rd[RST_BO_BIT]), 32'(rows[i].act & rows[i].below), "flag");
			$display("row %0d done", i);
		end
		below <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		apb(1'b1, OFS_RSTSRC, 32'h0000_0000);
		below <= 1'b1;
		repeat (6) @(posedge i_clk);
		chk(32'(cpu_reset), 32'h0000_0001, "reset held");
		pulse_low_supply(1);
		chk(32'(cpu_reset), 32'h0000_0000, "reset released");
		apb(1'b0, OFS_RSTSRC, 32'h0000_0000);
		chk(rd, 32'h0000_0020, "flag sticky");
		chk(32'(rst_cnt), 32'h0000_0004, "reset episodes");
		$display("hold test done");
		apb(1'b1, OFS_IRQ_CLR, 32'h0000_0003);
		apb(1'b1, OFS_CTRL, 32'h0000_00D0);
		pulse_low_supply(3);
		chk(32'(irq), 32'h0000_0000, "masked irq");
		apb(1'b1, OFS_IRQ_EN, 32'h0000_0002);
		repeat (2) @(posedge i_clk);
		chk(32'(irq), 32'h0000_0001, "enabled irq");
		apb(1'b1, OFS_IRQ_STA, 32'h0000_0000);
		apb(1'b0, OFS_IRQ_STA, 32'h0000_0000);
		chk(rd, 32'h0000_0003, "status read-only");
		apb(1'b1, OFS_IRQ_CLR, 32'h0000_0002);
		repeat (2) @(posedge i_clk);
		chk(32'(irq), 32'h0000_0000, "irq cleared");
		apb(1'b0, OFS_IRQ_STA, 32'h0000_0000);
		chk(rd, 32'h0000_0001, "status after clear");
		apb(1'b0, OFS_IRQ_CLR, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "clear reads zero");
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk({rd[30:0], err}, 32'h0000_0001, "unmapped");
		chk(32'(irq_cnt), 32'h0000_0002, "irq episodes");
		$display("irq test done");
		end_sim();
	end
endmodule

// File: verif/cpu_side_model.sv
// Purpose: Far-side model of the CPU reset and interrupt entry logic.
// Assumes: Reset and interrupt requests from the block are levels.
// Notes:   Counts reset episodes and interrupt entries for the bench.
`timescale 1ns/100ps
module cpu_side_model
(
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_cpu_reset,
	input  wire logic       i_brownout_irq,
	output logic      [7:0] o_reset_count,
	output logic      [7:0] o_irq_count
);
	logic rst_seen_reg;
	logic irq_seen_reg;

	// A held request counts once, since the core stays parked until release.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			rst_seen_reg  <= 1'b0;
			irq_seen_reg  <= 1'b0;
			o_reset_count <= 8'h00;
			o_irq_count   <= 8'h00;
		end
		else
		begin
			rst_seen_reg <= i_cpu_reset;
			irq_seen_reg <= i_brownout_irq;
			if (i_cpu_reset && !rst_seen_reg)
				o_reset_count <= o_reset_count + 8'h01;
			if (i_brownout_irq && !irq_seen_reg)
				o_irq_count <= o_irq_count + 8'h01;
		end
	end
endmodule
